// [src/spa_consts.vh]
`ifndef SPA_CONSTS_VH
`define SPA_CONSTS_VH
`define SPA_CLK_KHZ 20000
`define SPA_T50_MS 50
`define SPA_T100_MS 100
`define SPA_T250_MS 250
`define SPA_T500_MS 500
`define SPA_T1S_MS 1000
`define SPA_T2S_MS 2000
`define SPA_T5S_MS 5000
`define SPA_T10S_MS 10000
`define SPA_T20S_MS 20000
`define SPA_IV_50MS 4'h0
`define SPA_IV_100MS 4'h1
`define SPA_IV_250MS 4'h2
`define SPA_IV_500MS 4'h3
`define SPA_IV_1S 4'h4
`define SPA_IV_2S 4'h5
`define SPA_IV_5S 4'h6
`define SPA_IV_10S 4'h7
`define SPA_IV_20S 4'h8
`define SPA_A_CTRL 8'h00
`define SPA_A_GROUP 8'h04
`define SPA_A_HYST 8'h08
`define SPA_A_THR 8'h0C
`define SPA_A_STAT 8'h10
`define SPA_A_SRC 4'h2
`define SPA_A_RES 3'h2
`define SPA_CTRL_FILT 4
`define SPA_CTRL_INDEP 5
`define SPA_CTRL_RST 6'h00
`define SPA_GROUP_RST 8'h00
`define SPA_HYST_RST 16'h0080
`define SPA_THR_RST 16'h0200
`define SPA_SRC_RST 4'h0
`define SPA_SRC_EXT 4'h8
`define SPA_SRC_NONE 4'hF
`define SPA_DC_SHIFT 8
`define SPA_LP_SHIFT 2
`define SPA_CNT_CLAMP 2'h2
`endif

// [src/spa_top.v]
// How it works
// - short/long intervals use crossing-derived windows
// - mid-range intervals average the whole interval
// - window spans whole source periods
// - result is mean of samples in window
// - source: element U/I, external, none; installed only
// - crossings flagged at zero on each slope
// - window from first to last same-polarity crossing
// - polarity giving longer window chosen automatically
// - under two crossings: use whole interval
// - low AC amplitude: use whole interval
// - hysteresis suppresses small noise crossings
// - optional filter feeds crossing detector
// - detection path is AC coupled
// - no source: average every sample
// - linked mode: source write covers wiring group
// - independent mode: per-element source
//
// Our own choices: the register addresses and the APB slave port.
`timescale 1ns/1ns
`default_nettype none
`include "spa_consts.vh"
module spa_top #(
   parameter SW = 16,
   parameter AW = 48,
   parameter CW = 32,
   parameter N_ELEM = 4,
   parameter [31:0] CYC_50MS = `SPA_T50_MS * `SPA_CLK_KHZ,
   parameter [31:0] CYC_100MS = `SPA_T100_MS * `SPA_CLK_KHZ,
   parameter [31:0] CYC_250MS = `SPA_T250_MS * `SPA_CLK_KHZ,
   parameter [31:0] CYC_500MS = `SPA_T500_MS * `SPA_CLK_KHZ,
   parameter [31:0] CYC_1S = `SPA_T1S_MS * `SPA_CLK_KHZ,
   parameter [31:0] CYC_2S = `SPA_T2S_MS * `SPA_CLK_KHZ,
   parameter [31:0] CYC_5S = `SPA_T5S_MS * `SPA_CLK_KHZ,
   parameter [31:0] CYC_10S = `SPA_T10S_MS * `SPA_CLK_KHZ,
   parameter [31:0] CYC_20S = `SPA_T20S_MS * `SPA_CLK_KHZ
) (
   input wire core_clk,
   input wire sys_rst,
   input wire psel,
   input wire penable,
   input wire pwrite,
   input wire [7:0] paddr,
   input wire [31:0] pwdata,
   output reg [31:0] prdata,
   output reg pready,
   output reg pslverr,
   input wire sample_valid,
   input wire [SW-1:0] element_one_voltage,
   input wire [SW-1:0] element_one_current,
   input wire [SW-1:0] element_two_voltage,
   input wire [SW-1:0] element_two_current,
   input wire [SW-1:0] element_three_voltage,
   input wire [SW-1:0] element_three_current,
   input wire [SW-1:0] element_four_voltage,
   input wire [SW-1:0] element_four_current,
   input wire ext_sync_clk,
   output reg results_updated
);
   localparam D_IDLE = 3'd0;
   localparam D_LOAD = 3'd1;
   localparam D_ITER = 3'd2;
   localparam D_NEXT = 3'd3;
   localparam D_PUB = 3'd4;

   reg [5:0] ctrl_reg;
   reg [7:0] group_reg;
   reg [SW-1:0] hyst_reg;
   reg [SW-1:0] thr_reg;
   reg [3:0] src_reg [0:3];
   reg [31:0] iv_cnt_reg;
   reg [CW-1:0] cnt_reg;
   reg [AW-1:0] sum_reg [0:7];
   reg [AW-1:0] rf_sum [0:7];
   reg [AW-1:0] rl_sum [0:7];
   reg [AW-1:0] ff_sum [0:7];
   reg [AW-1:0] fl_sum [0:7];
   reg [CW-1:0] rf_cnt [0:3];
   reg [CW-1:0] rl_cnt [0:3];
   reg [CW-1:0] ff_cnt [0:3];
   reg [CW-1:0] fl_cnt [0:3];
   reg [1:0] nr_reg [0:3];
   reg [1:0] nf_reg [0:3];
   reg [AW-1:0] num_reg [0:7];
   reg [CW-1:0] den_reg [0:3];
   reg [3:0] synced_reg;
   reg [3:0] fall_used_reg;
   reg go_reg;
   reg [2:0] dstate_reg;
   reg [2:0] ch_reg;
   reg [AW-1:0] quo_reg;
   reg [CW:0] rem_reg;
   reg [CW-1:0] dvs_reg;
   reg neg_reg;
   reg [6:0] bit_reg;
   reg [31:0] stage_reg [0:7];
   reg [31:0] res_reg [0:7];
   reg [7:0] seq_reg;
   reg ext_s1, ext_s2, ext_s3;
   reg [31:0] rd_mux;
   integer i;

   wire [8*SW-1:0] smp_bus = {element_four_current, element_four_voltage,
      element_three_current, element_three_voltage,
      element_two_current, element_two_voltage,
      element_one_current, element_one_voltage};
   wire [3:0] iv_code = ctrl_reg[3:0];
   // mid-range intervals never use the crossing window
   wire sync_iv = (iv_code < `SPA_IV_250MS) || (iv_code > `SPA_IV_2S);

   function [31:0] iv_lim;
      input [3:0] code;
      begin
         case (code)
            `SPA_IV_50MS: iv_lim = CYC_50MS;
            `SPA_IV_100MS: iv_lim = CYC_100MS;
            `SPA_IV_250MS: iv_lim = CYC_250MS;
            `SPA_IV_500MS: iv_lim = CYC_500MS;
            `SPA_IV_1S: iv_lim = CYC_1S;
            `SPA_IV_2S: iv_lim = CYC_2S;
            `SPA_IV_5S: iv_lim = CYC_5S;
            `SPA_IV_10S: iv_lim = CYC_10S;
            default: iv_lim = CYC_20S;
         endcase
      end
   endfunction

   function [AW-1:0] sx;
      input [SW-1:0] v;
      begin
         sx = {{(AW-SW){v[SW-1]}}, v};
      end
   endfunction

   function src_ok;
      input [3:0] code;
      begin
         src_ok = (code == `SPA_SRC_NONE) || (code == `SPA_SRC_EXT) ||
            (code < `SPA_SRC_EXT && code[3:1] < N_ELEM);
      end
   endfunction

   // a change to a shorter code mid-interval ends the current interval at once if the count is already past the new limit
   wire iv_end = (iv_cnt_reg >= iv_lim(iv_code) - 32'h0000_0001);

   wire [7:0] det_rise, det_fall, det_amp;
   genvar g;
   generate
      for (g = 0; g < 8; g = g + 1) begin : gdet
         spa_xdet #(.SW(SW)) u_det (
            .core_clk(core_clk),
            .sys_rst(sys_rst),
            .smp_valid(sample_valid),
            .smp(smp_bus[g*SW +: SW]),
            .filt_en(ctrl_reg[`SPA_CTRL_FILT]),
            .hyst(hyst_reg),
            .thresh(thr_reg),
            .peak_clr(iv_end),
            .rise_pulse(det_rise[g]),
            .fall_pulse(det_fall[g]),
            .amp_ok(det_amp[g])
         );
      end
   endgenerate

   // unused codes index zeros, so a none source never sees events
   wire [15:0] rise_bus = {7'h00, ext_s2 & ~ext_s3, det_rise};
   wire [15:0] fall_bus = {7'h00, ~ext_s2 & ext_s3, det_fall};
   wire [15:0] amp_bus = {7'h00, 1'b1, det_amp};

   wire [3:0] ev_rise, ev_fall, use_sync, use_fall;
   generate
      for (g = 0; g < 4; g = g + 1) begin : gdec
         wire [3:0] s = src_reg[g];
         wire vr = nr_reg[g] == `SPA_CNT_CLAMP;
         wire vf = nf_reg[g] == `SPA_CNT_CLAMP;
         wire [CW-1:0] lr = rl_cnt[g] - rf_cnt[g];
         wire [CW-1:0] lf = fl_cnt[g] - ff_cnt[g];
         assign ev_rise[g] = rise_bus[s];
         assign ev_fall[g] = fall_bus[s];
         assign use_sync[g] = sync_iv && s != `SPA_SRC_NONE &&
            amp_bus[s] && (vr || vf);
         assign use_fall[g] = vf && (!vr || lf > lr);
      end
   endgenerate

   // apb: zero wait states, answer prepared in the setup cycle
   wire setup = psel & ~penable;
   wire wr_acc = psel & penable & pready & pwrite;
   wire is_src = paddr[7:4] == `SPA_A_SRC && paddr[1:0] == 2'b00;
   wire is_res = paddr[7:5] == `SPA_A_RES && paddr[1:0] == 2'b00;
   wire [1:0] src_w = paddr[3:2];
   wire addr_ok = paddr == `SPA_A_CTRL || paddr == `SPA_A_GROUP ||
      paddr == `SPA_A_HYST || paddr == `SPA_A_THR ||
      paddr == `SPA_A_STAT || is_src || is_res;

   always @* begin
      rd_mux = 32'h0000_0000;
      if (is_src) begin
         rd_mux[3:0] = src_reg[src_w];
      end else if (is_res) begin
         rd_mux = res_reg[paddr[4:2]];
      end else begin
         case (paddr)
            `SPA_A_CTRL: rd_mux[5:0] = ctrl_reg;
            `SPA_A_GROUP: rd_mux[7:0] = group_reg;
            `SPA_A_HYST: rd_mux[SW-1:0] = hyst_reg;
            `SPA_A_THR: rd_mux[SW-1:0] = thr_reg;
            `SPA_A_STAT: rd_mux[24:0] = {dstate_reg != D_IDLE, seq_reg,
               8'h00, fall_used_reg, synced_reg};
            default: rd_mux = 32'h0000_0000;
         endcase
      end
   end

   always @(posedge core_clk) begin
      if (sys_rst) begin
         pready <= 1'b0;
         pslverr <= 1'b0;
         prdata <= 32'h0000_0000;
         ctrl_reg <= `SPA_CTRL_RST;
         group_reg <= `SPA_GROUP_RST;
         hyst_reg <= `SPA_HYST_RST;
         thr_reg <= `SPA_THR_RST;
         for (i = 0; i < 4; i = i + 1) begin
            src_reg[i] <= `SPA_SRC_RST;
         end
      end else begin
         pready <= setup;
         // error flag stands only beside its ready
         pslverr <= setup & ~addr_ok;
         if (setup) begin
            prdata <= pwrite ? 32'h0000_0000 : rd_mux;
         end
         if (wr_acc) begin
            case (paddr)
               `SPA_A_CTRL: ctrl_reg <= pwdata[5:0];
               `SPA_A_GROUP: group_reg <= pwdata[7:0];
               `SPA_A_HYST: hyst_reg <= pwdata[SW-1:0];
               `SPA_A_THR: thr_reg <= pwdata[SW-1:0];
               default: ;
            endcase
            if (is_src && src_ok(pwdata[3:0]) && src_w < N_ELEM) begin
               for (i = 0; i < 4; i = i + 1) begin
                  if (i == src_w) begin
                     src_reg[i] <= pwdata[3:0];
                  end else if (!ctrl_reg[`SPA_CTRL_INDEP] &&
                     group_reg[2*i +: 2] == group_reg[2*src_w +: 2]) begin
                     src_reg[i] <= pwdata[3:0];
                  end
               end
            end
         end
      end
   end

   // external sync pin: the second and third stages feed the edge logic
   always @(posedge core_clk) begin
      if (sys_rst) begin
         ext_s1 <= 1'b0;
         ext_s2 <= 1'b0;
         ext_s3 <= 1'b0;
      end else begin
         ext_s1 <= ext_sync_clk;
         ext_s2 <= ext_s1;
         ext_s3 <= ext_s2;
      end
   end

   // prefix sums: crossing snapshots make any window a difference
   always @(posedge core_clk) begin
      if (sys_rst) begin
         iv_cnt_reg <= 32'h0000_0000;
         cnt_reg <= {CW{1'b0}};
         go_reg <= 1'b0;
         synced_reg <= 4'h0;
         fall_used_reg <= 4'h0;
         for (i = 0; i < 8; i = i + 1) begin
            sum_reg[i] <= {AW{1'b0}};
            rf_sum[i] <= {AW{1'b0}};
            rl_sum[i] <= {AW{1'b0}};
            ff_sum[i] <= {AW{1'b0}};
            fl_sum[i] <= {AW{1'b0}};
            num_reg[i] <= {AW{1'b0}};
         end
         for (i = 0; i < 4; i = i + 1) begin
            rf_cnt[i] <= {CW{1'b0}};
            rl_cnt[i] <= {CW{1'b0}};
            ff_cnt[i] <= {CW{1'b0}};
            fl_cnt[i] <= {CW{1'b0}};
            nr_reg[i] <= 2'h0;
            nf_reg[i] <= 2'h0;
            den_reg[i] <= {CW{1'b0}};
         end
      end else begin
         go_reg <= iv_end;
         iv_cnt_reg <= iv_end ? 32'h0000_0000 : iv_cnt_reg + 32'h0000_0001;
         cnt_reg <= (iv_end ? {CW{1'b0}} : cnt_reg) +
            {{(CW-1){1'b0}}, sample_valid};
         for (i = 0; i < 8; i = i + 1) begin
            sum_reg[i] <= (iv_end ? {AW{1'b0}} : sum_reg[i]) +
               (sample_valid ? sx(smp_bus[i*SW +: SW]) : {AW{1'b0}});
         end
         for (i = 0; i < 4; i = i + 1) begin
            if (iv_end) begin
               nr_reg[i] <= 2'h0;
               nf_reg[i] <= 2'h0;
               synced_reg[i] <= use_sync[i];
               fall_used_reg[i] <= use_sync[i] & use_fall[i];
               if (use_sync[i] && use_fall[i]) begin
                  num_reg[2*i] <= fl_sum[2*i] - ff_sum[2*i];
                  num_reg[2*i+1] <= fl_sum[2*i+1] - ff_sum[2*i+1];
                  den_reg[i] <= fl_cnt[i] - ff_cnt[i];
               end else if (use_sync[i]) begin
                  num_reg[2*i] <= rl_sum[2*i] - rf_sum[2*i];
                  num_reg[2*i+1] <= rl_sum[2*i+1] - rf_sum[2*i+1];
                  den_reg[i] <= rl_cnt[i] - rf_cnt[i];
               end else begin
                  num_reg[2*i] <= sum_reg[2*i];
                  num_reg[2*i+1] <= sum_reg[2*i+1];
                  den_reg[i] <= cnt_reg;
               end
            end else begin
               if (ev_rise[i]) begin
                  if (nr_reg[i] == 2'h0) begin
                     rf_sum[2*i] <= sum_reg[2*i];
                     rf_sum[2*i+1] <= sum_reg[2*i+1];
                     rf_cnt[i] <= cnt_reg;
                  end else begin
                     nr_reg[i] <= `SPA_CNT_CLAMP;
                  end
                  if (nr_reg[i] == 2'h0) nr_reg[i] <= 2'h1;
                  rl_sum[2*i] <= sum_reg[2*i];
                  rl_sum[2*i+1] <= sum_reg[2*i+1];
                  rl_cnt[i] <= cnt_reg;
               end
               if (ev_fall[i]) begin
                  if (nf_reg[i] == 2'h0) begin
                     ff_sum[2*i] <= sum_reg[2*i];
                     ff_sum[2*i+1] <= sum_reg[2*i+1];
                     ff_cnt[i] <= cnt_reg;
                  end else begin
                     nf_reg[i] <= `SPA_CNT_CLAMP;
                  end
                  if (nf_reg[i] == 2'h0) nf_reg[i] <= 2'h1;
                  fl_sum[2*i] <= sum_reg[2*i];
                  fl_sum[2*i+1] <= sum_reg[2*i+1];
                  fl_cnt[i] <= cnt_reg;
               end
            end
         end
      end
   end

   // one shared restoring divider; intervals must outlast its ~400 cycles
   wire [CW:0] rem_sh = {rem_reg[CW-1:0], quo_reg[AW-1]};
   wire rem_ge = rem_sh >= {1'b0, dvs_reg};
   wire [31:0] q32 = quo_reg[31:0];

   always @(posedge core_clk) begin
      if (sys_rst) begin
         dstate_reg <= D_IDLE;
         ch_reg <= 3'd0;
         quo_reg <= {AW{1'b0}};
         rem_reg <= {(CW+1){1'b0}};
         dvs_reg <= {CW{1'b0}};
         neg_reg <= 1'b0;
         bit_reg <= 7'd0;
         seq_reg <= 8'h00;
         results_updated <= 1'b0;
         for (i = 0; i < 8; i = i + 1) begin
            stage_reg[i] <= 32'h0000_0000;
            res_reg[i] <= 32'h0000_0000;
         end
      end else begin
         results_updated <= 1'b0;
         case (dstate_reg)
            D_IDLE: begin
               ch_reg <= 3'd0;
               if (go_reg) dstate_reg <= D_LOAD;
            end
            D_LOAD: begin
               neg_reg <= num_reg[ch_reg][AW-1];
               quo_reg <= num_reg[ch_reg][AW-1] ? -num_reg[ch_reg] : num_reg[ch_reg];
               dvs_reg <= den_reg[ch_reg[2:1]];
               rem_reg <= {(CW+1){1'b0}};
               bit_reg <= AW[6:0];
               dstate_reg <= D_ITER;
            end
            D_ITER: begin
               rem_reg <= rem_ge ? rem_sh - {1'b0, dvs_reg} : rem_sh;
               quo_reg <= {quo_reg[AW-2:0], rem_ge};
               bit_reg <= bit_reg - 7'd1;
               if (bit_reg == 7'd1) dstate_reg <= D_NEXT;
            end
            D_NEXT: begin
               // mean of the window samples, empty window reads zero
               if (dvs_reg == {CW{1'b0}}) stage_reg[ch_reg] <= 32'h0000_0000;
               else stage_reg[ch_reg] <= neg_reg ? -q32 : q32;
               ch_reg <= ch_reg + 3'd1;
               dstate_reg <= (ch_reg == 3'd7) ? D_PUB : D_LOAD;
            end
            D_PUB: begin
               for (i = 0; i < 8; i = i + 1) begin
                  res_reg[i] <= stage_reg[i];
               end
               seq_reg <= seq_reg + 8'h01;
               results_updated <= 1'b1;
               dstate_reg <= D_IDLE;
            end
            default: dstate_reg <= D_IDLE;
         endcase
      end
   end
endmodule // spa_top
`default_nettype wire

// [src/spa_xdet.v]
`timescale 1ns/1ns
`default_nettype none
`include "spa_consts.vh"
module spa_xdet #(
   parameter SW = 16
) (
   input wire core_clk,
   input wire sys_rst,
   input wire smp_valid,
   input wire [SW-1:0] smp,
   input wire filt_en,
   input wire [SW-1:0] hyst,
   input wire [SW-1:0] thresh,
   input wire peak_clr,
   output reg rise_pulse,
   output reg fall_pulse,
   output wire amp_ok
);
   localparam IW = SW + 2;
   localparam DW = IW + `SPA_DC_SHIFT;
   localparam LW = IW + `SPA_LP_SHIFT;
   reg signed [DW-1:0] dc_reg;
   reg signed [LW-1:0] lp_reg;
   reg pos_reg;
   reg [IW-1:0] peak_reg;
   wire signed [IW-1:0] dc_int = dc_reg[DW-1:`SPA_DC_SHIFT];
   wire signed [IW-1:0] lp_int = lp_reg[LW-1:`SPA_LP_SHIFT];
   wire signed [IW-1:0] x_ext = {{2{smp[SW-1]}}, smp};
   // dc estimate removed so offset signals still cross
   wire signed [IW-1:0] ac = x_ext - dc_int;
   wire signed [IW-1:0] lp_diff = ac - lp_int;
   wire signed [IW-1:0] sig = filt_en ? lp_int : ac;
   wire signed [IW-1:0] hyst_p = {2'b00, hyst};
   wire signed [IW-1:0] hyst_n = -hyst_p;
   wire [IW-1:0] mag = sig[IW-1] ? -sig : sig;
   assign amp_ok = peak_reg >= {2'b00, thresh};
   always @(posedge core_clk) begin
      if (sys_rst) begin
         dc_reg <= {DW{1'b0}};
         lp_reg <= {LW{1'b0}};
         pos_reg <= 1'b0;
         peak_reg <= {IW{1'b0}};
         rise_pulse <= 1'b0;
         fall_pulse <= 1'b0;
      end else begin
         rise_pulse <= 1'b0;
         fall_pulse <= 1'b0;
         if (peak_clr) begin
            peak_reg <= smp_valid ? mag : {IW{1'b0}};
         end else if (smp_valid && mag > peak_reg) begin
            peak_reg <= mag;
         end
         if (smp_valid) begin
            dc_reg <= dc_reg + {{(DW-IW){ac[IW-1]}}, ac};
            lp_reg <= lp_reg + {{(LW-IW){lp_diff[IW-1]}}, lp_diff};
            // noise inside the band never toggles the slope state
            if (!pos_reg && sig > hyst_p) begin
               pos_reg <= 1'b1;
               rise_pulse <= 1'b1;
            end else if (pos_reg && sig < hyst_n) begin
               pos_reg <= 1'b0;
               fall_pulse <= 1'b1;
            end
         end
      end
   end
endmodule // spa_xdet
`default_nettype wire

// [tb/spa_src_model.sv]
`timescale 1ns/1ns
`default_nettype none
module spa_src_model (
   input wire logic core_clk,
   input wire logic sys_rst,
   input wire logic [15:0] half_per,
   input wire logic [15:0] amp,
   input wire logic [15:0] ofs,
   input wire logic ext_on,
   output logic sample_valid,
   output logic [15:0] wave,
   output logic ext_sync_clk
);
   logic [15:0] ph_reg;
   logic pol_reg;
   // square wave: whole periods average exactly to the offset
   assign wave = pol_reg ? ofs + amp : ofs - amp;
   // external clock rests low while disabled, as an idle pin would
   assign ext_sync_clk = ext_on & pol_reg;
   always @(posedge core_clk) begin
      if (sys_rst) begin
         ph_reg <= 16'h0000;
         pol_reg <= 1'b0;
         sample_valid <= 1'b0;
      end else begin
         sample_valid <= 1'b1;
         ph_reg <= ph_reg + 16'h0001;
         if (ph_reg >= half_per - 16'h0001) begin
            ph_reg <= 16'h0000;
            pol_reg <= ~pol_reg;
         end
      end
   end
endmodule // spa_src_model
`default_nettype wire

// [tb/spa_top_assertions.sv]
`timescale 1ns/1ns
`default_nettype none
module spa_top_chk #(
   parameter [31:0] CYC_50MS = 32'h0000_03E8
) (
   input wire logic core_clk,
   input wire logic sys_rst,
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [7:0] paddr,
   input wire logic [31:0] prdata,
   input wire logic pready,
   input wire logic pslverr,
   input wire logic results_updated
);
   logic [31:0] gap_reg;
   default clocking cb @(posedge core_clk);
   endclocking
   default disable iff (sys_rst);
   // cycles since the last publish, counted from reset too
   always @(posedge core_clk) begin
      if (sys_rst || results_updated) begin
         gap_reg <= 32'h0000_0000;
      end else begin
         gap_reg <= gap_reg + 32'h0000_0001;
      end
   end
   AST_READY_AFTER_SETUP:
      assert property (psel && !penable |=> pready) else $error("no ready after setup");
   AST_READY_ONE_CYCLE:
      assert property (pready |=> !pready) else $error("ready held too long");
   AST_READY_CAUSE:
      assert property ($rose(pready) |-> $past(psel && !penable)) else $error("stray ready");
   AST_ERR_WITH_READY:
      assert property (pslverr |-> pready) else $error("error without ready");
   AST_WRITE_RDATA_ZERO:
      assert property (pready && pwrite |-> prdata == 32'h0) else $error("write data nonzero");
   AST_UNMAPPED_ERR:
      assert property (pready && psel && paddr == 8'h14 |-> pslverr) else $error("no error");
   AST_MAPPED_OK:
      assert property (pready && psel && paddr == 8'h00 |-> !pslverr) else $error("bad error");
   AST_PUB_PULSE:
      assert property (results_updated |=> !results_updated [*8]) else $error("publish long");
   AST_PUB_GAP:
      assert property (results_updated |-> gap_reg >= (CYC_50MS >> 1))
         else $error("publish too soon");
   cover property (results_updated);
   cover property (pslverr);
   cover property (pready && pwrite);
endmodule // spa_top_chk
bind spa_top spa_top_chk #(.CYC_50MS(CYC_50MS)) i_chk (
   .core_clk(core_clk), .sys_rst(sys_rst), .psel(psel), .penable(penable),
   .pwrite(pwrite), .paddr(paddr), .prdata(prdata), .pready(pready),
   .pslverr(pslverr), .results_updated(results_updated)
);
`default_nettype wire

// [tb/testbench.sv]
`timescale 1ns/1ns
`default_nettype none
`include "spa_consts.vh"
module testbench;
   localparam logic [31:0] IVL = 32'h0000_03E8;
   logic core_clk = 1'b0;
   logic sys_rst = 1'b1;
   logic psel = 1'b0;
   logic penable = 1'b0;
   logic pwrite = 1'b0;
   logic [7:0] paddr = 8'h00;
   logic [31:0] pwdata = 32'h0;
   logic [15:0] half_per = 16'h0046;
   logic [15:0] amp = 16'h1000;
   logic [15:0] ofs = 16'h1800;
   logic ext_on = 1'b0;
   logic [31:0] prdata;
   logic pready, pslverr, results_updated, sample_valid, ext_sync_clk;
   logic [15:0] wave;
   int error_cnt = 0;
   int samples_checked = 0;
   int cyc_cnt = 0;
   spa_src_model i_src (.core_clk(core_clk), .sys_rst(sys_rst), .half_per(half_per),
      .amp(amp), .ofs(ofs), .ext_on(ext_on), .sample_valid(sample_valid), .wave(wave),
      .ext_sync_clk(ext_sync_clk));
   spa_top #(.CYC_50MS(IVL), .CYC_100MS(IVL), .CYC_250MS(IVL), .CYC_500MS(IVL),
      .CYC_1S(IVL), .CYC_2S(IVL), .CYC_5S(IVL), .CYC_10S(IVL), .CYC_20S(IVL)) i_dut (
      .core_clk(core_clk), .sys_rst(sys_rst), .psel(psel), .penable(penable),
      .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
      .pslverr(pslverr), .sample_valid(sample_valid),
      .element_one_voltage(wave), .element_one_current(ofs),
      .element_two_voltage(wave), .element_two_current(ofs),
      .element_three_voltage(wave), .element_three_current(ofs),
      .element_four_voltage(wave), .element_four_current(ofs),
      .ext_sync_clk(ext_sync_clk), .results_updated(results_updated));
   initial begin
      forever #25 core_clk = ~core_clk;
   end
   task automatic tally_and_finish;
      $display("checks %0d mismatches %0d", samples_checked, error_cnt);
      if (error_cnt == 0 && samples_checked > 0) begin
         $display("Regression OK");
      end else begin
         $display("Regression broken");
      end
      $finish;
   endtask
   // longest run is about 51k cycles
   always @(posedge core_clk) begin
      cyc_cnt++;
      if (cyc_cnt == 80000) begin
         error_cnt++;
         tally_and_finish();
      end
   end
   task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
      samples_checked++;
      if (seen !== exp) begin
         error_cnt++;
         $display("MISMATCH %s expected %h seen %h", nm, exp, seen);
      end
   endtask
   // ready, data and error are taken at the rising edge that ends the access
   task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d,
      output logic [31:0] r, output logic e);
      @(posedge core_clk);
      psel <= 1'b1;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge core_clk);
      penable <= 1'b1;
      do @(posedge core_clk); while (pready !== 1'b1);
      r = prdata;
      e = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
   endtask
   task automatic wr(input logic [7:0] a, input logic [31:0] d);
      logic [31:0] r;
      logic e;
      apb(1'b1, a, d, r, e);
   endtask
   task automatic rd(input logic [7:0] a, output logic [31:0] r);
      logic e;
      apb(1'b0, a, 32'h0, r, e);
   endtask
   function automatic logic [7:0] sa(input logic [1:0] el);
      return {`SPA_A_SRC, el, 2'b00};
   endfunction
   task automatic wait_pub(input int n);
      while (n > 0) begin
         @(negedge core_clk);
         if (results_updated === 1'b1) n--;
      end
   endtask
   // a pending publish and the next one may both span a change; take the third
   task automatic run_meas(input logic [31:0] ctrl, output logic [31:0] st);
      wr(`SPA_A_CTRL, ctrl);
      wait_pub(3);
      rd(`SPA_A_STAT, st);
   endtask
   task automatic t_regs;
      logic [31:0] r;
      logic e;
      rd(`SPA_A_HYST, r);
      chk("hyst reset", r, {16'h0, `SPA_HYST_RST});
      rd(`SPA_A_THR, r);
      chk("thr reset", r, {16'h0, `SPA_THR_RST});
      rd(sa(2'h0), r);
      chk("src reset", r, {28'h0, `SPA_SRC_RST});
      apb(1'b0, 8'h14, 32'h0, r, e);
      chk("unmapped error", {31'h0, e}, 32'h1);
      apb(1'b1, `SPA_A_STAT, 32'hFFFF_FFFF, r, e);
      chk("read-only write error", {31'h0, e}, 32'h0);
      wr(sa(2'h0), 32'h0000_0009);
      rd(sa(2'h0), r);
      chk("invalid source ignored", r, 32'h0);
   endtask
   task automatic t_link;
      logic [31:0] r;
      wr(`SPA_A_GROUP, 32'h0);
      wr(`SPA_A_CTRL, 32'h0);
      wr(sa(2'h1), 32'h3);
      for (int i = 0; i < 4; i++) begin
         rd(sa(i[1:0]), r);
         chk("linked source", r, 32'h3);
      end
      wr(`SPA_A_CTRL, 32'h20);
      wr(sa(2'h2), 32'h5);
      rd(sa(2'h2), r);
      chk("own source", r, 32'h5);
      rd(sa(2'h0), r);
      chk("neighbour kept", r, 32'h3);
      wr(`SPA_A_CTRL, 32'h0);
      wr(sa(2'h0), 32'h0);
   endtask
   task automatic t_sync;
      logic [31:0] st;
      logic [31:0] r;
      logic signed [31:0] d;
      wait_pub(1);
      run_meas(32'h0, st);
      chk("crossing window", {31'h0, st[0]}, 32'h1);
      rd({`SPA_A_RES, 3'h0, 2'b00}, r);
      d = r - 32'h0000_1800;
      chk("mean over whole periods", {31'h0, (d < 32'sh40) && (d > -32'sh40)}, 32'h1);
      rd({`SPA_A_RES, 3'h1, 2'b00}, r);
      chk("current mean", r, 32'h0000_1800);
      wait_pub(1);
      rd(`SPA_A_STAT, r);
      chk("publish sequence", {24'h0, r[23:16]}, {24'h0, st[23:16] + 8'h01});
   endtask
   task automatic t_codes;
      logic [31:0] st;
      for (int c = 0; c < 9; c++) begin
         run_meas({28'h0, c[3:0]}, st);
         chk("window per code", {31'h0, st[0]}, (c >= 2 && c <= 5) ? 32'h0 : 32'h1);
      end
      run_meas(32'h10, st);
      chk("filtered crossings", {31'h0, st[0]}, 32'h1);
   endtask
   task automatic t_fallback;
      logic [31:0] st;
      @(posedge core_clk);
      amp <= 16'h0100;
      run_meas(32'h0, st);
      chk("small amplitude", {31'h0, st[0]}, 32'h0);
      amp <= 16'h0040;
      wr(`SPA_A_THR, 32'h10);
      run_meas(32'h0, st);
      chk("noise inside band", {31'h0, st[0]}, 32'h0);
      wr(`SPA_A_THR, {16'h0, `SPA_THR_RST});
      amp <= 16'h1000;
      half_per <= 16'h07D0;
      run_meas(32'h0, st);
      chk("single crossing", {31'h0, st[0]}, 32'h0);
      half_per <= 16'h0046;
   endtask
   task automatic t_src_kinds;
      logic [31:0] st;
      logic [31:0] r;
      wr(sa(2'h0), {28'h0, `SPA_SRC_NONE});
      run_meas(32'h0, st);
      chk("no source", {31'h0, st[0]}, 32'h0);
      rd({`SPA_A_RES, 3'h1, 2'b00}, r);
      chk("no source mean", r, 32'h0000_1800);
      wr(sa(2'h0), {28'h0, `SPA_SRC_EXT});
      ext_on <= 1'b1;
      run_meas(32'h0, st);
      chk("external source", {31'h0, st[0]}, 32'h1);
   endtask
   initial begin
      repeat (20) @(posedge core_clk);
      sys_rst <= 1'b0;
      @(posedge core_clk);
      t_regs();
      t_link();
      t_sync();
      t_codes();
      t_fallback();
      t_src_kinds();
      tally_and_finish();
   end
endmodule // testbench
`default_nettype wire
